// ===== design/tcpm_pkg.sv
// constants for the touch controller mode and power control block
// assumes a 250 MHz core clock and a register port of address and byte data
package tcpm_pkg;
	localparam logic [7:0] TICK_PERIOD_OFS = 8'h0e;
	localparam logic [7:0] MODE_CTRL_OFS   = 8'h13;
	localparam logic [7:0] TICK_RESET      = 8'h05;
	localparam logic [7:0] MODE_RESET      = 8'h14;
	localparam logic [7:0] TICK_CODE_MAX   = 8'h1a;
	localparam int         TICK_BASE_MS    = 5;
	localparam int         FIXED_TICK_MS   = 8;
	localparam int         CLK_MHZ         = 250;
	localparam int         CYC_PER_MS      = CLK_MHZ * 1000;
	localparam int         FIXED_TICK_CYC  = FIXED_TICK_MS * CYC_PER_MS;
	localparam int         SPACE_POS       = 5;
	localparam int         GRST_POS        = 4;
	localparam int         UNIMP_POS       = 3;
	localparam int         DUTY_POS        = 2;
	localparam int         IRQ_OUTPUT_ENABLE_POS       = 1;
	localparam int         SCAN_POS        = 0;
	typedef enum logic [1:0] {
		TCPM_STOP_OFF        = 2'b00,
		TCPM_STOP_ACCESSIBLE = 2'b01,
		TCPM_RUN_CONTINUOUS  = 2'b11,
		TCPM_RUN_DUTY_CYCLED = 2'b10
	} tcpm_mode_t;
endpackage

// ===== design/tcpm_sync.sv
// two-flop synchroniser with falling edge detect on the synchronised level
// assumes the input is asynchronous to CLK
`timescale 1ns/100ps
module tcpm_sync (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic din,
	output logic      level,
	output logic      fall
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			last_reg <= 1'b1;
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end
	assign level = sync_reg;
	// one pulse per falling edge, from the stable stage only
	assign fall  = last_reg & ~sync_reg;
endmodule

// ===== design/tcpm_tick.sv
// master tick counter: pulses once per period of the given cycle count
// assumes period_cyc stays at least 1
`timescale 1ns/100ps
module tcpm_tick #(
	parameter int W = 24
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         run,
	input  wire logic [W-1:0] period_cyc,
	output logic              tick
);
	logic [W-1:0] cnt_reg;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			tick    <= 1'b0;
		end else if (!run) begin
			cnt_reg <= '0;
			tick    <= 1'b0;
		end else if (cnt_reg >= period_cyc - W'(1)) begin
			// >= so a shortened period takes effect at once
			cnt_reg <= '0;
			tick    <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + W'(1);
			tick    <= 1'b0;
		end
	end
endmodule

// ===== design/tcpm_top.sv
// operating mode and power control for a capacitive touch controller
// assumes register accesses arrive as one-cycle strobes from the serial
// slave, and the wake pin is asynchronous to CLK
//
// Overview of operation
// - both bits high: continuous scan, bus available
// - continuous run: modules timed by master tick
// - other modes: fixed eight millisecond primary clock; no tick runs in either stop mode
// - tick period is code plus five milliseconds
// - out-of-range tick code forced to twenty-six
// - duty-cycled run: scan, low power between
// - accessible stop: no scan, registers answer
// - tick register writes only in accessible stop
// - both bits low: no scan, no bus
// - only wake pin toggle exits low modes
// - interrupt spacing is tick times code plus one
// - bit four zero asserts global reset
// - bit two low enables duty cycling
// - bit one enables interrupt output
// - bit zero enables electrode scanning
// - wake pin fall sets duty bit
// - wake fall alone reopens bus in low modes
// - mode register resets to 0x14
// - in continuous run only mode register writable
`timescale 1ns/100ps
module tcpm_top #(
	parameter int CNT_W          = 24,
	parameter int FIXED_TICK_CYC = tcpm_pkg::FIXED_TICK_CYC,
	parameter int CYC_PER_MS     = tcpm_pkg::CYC_PER_MS
) (
	input  wire logic       CLK,
	input  wire logic       RST_B,
	input  wire logic       WAKE_PIN,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	output logic [7:0]      REG_RDATA,
	output logic            REG_ACK,
	input  wire logic       IRQ_REQ,
	output logic            IRQ_PULSE,
	output logic            BUS_AVAIL,
	output logic            SCAN_ACTIVE,
	output logic            LOW_POWER,
	output logic            TICK,
	output logic            GLOBAL_RST_N,
	output logic [1:0]      MODE
);
	logic       wake_level;
	logic       wake_fall;
	logic [7:0] tick_period_reg;
	logic [7:0] mode_reg;
	logic [3:0] space_cnt_reg;
	logic       irq_pend_reg;
	logic [CNT_W-1:0] period_cyc;
	logic       scan_enable;
	logic       duty_cycle_off_n;
	logic       irq_output_enable;
	logic [2:0] irq_spacing_factor;
	logic       bus_open;
	logic       wr_mode;
	logic       wr_tick;
	tcpm_pkg::tcpm_mode_t mode;

	// wake pin passes two flops before the edge detector
	tcpm_sync u_sync (
		.clk   (CLK),
		.rst_b (RST_B),
		.din   (WAKE_PIN),
		.level (wake_level),
		.fall  (wake_fall)
	);

	assign scan_enable        = mode_reg[tcpm_pkg::SCAN_POS];
	assign duty_cycle_off_n   = mode_reg[tcpm_pkg::DUTY_POS];
	assign irq_output_enable  = mode_reg[tcpm_pkg::IRQ_OUTPUT_ENABLE_POS];
	assign irq_spacing_factor = mode_reg[7:tcpm_pkg::SPACE_POS];
	assign mode = tcpm_pkg::tcpm_mode_t'({scan_enable, duty_cycle_off_n});

	// only the accessible-stop and continuous modes talk on the bus
	assign bus_open = duty_cycle_off_n;
	assign wr_mode  = REG_WR & bus_open &
		(REG_ADDR == tcpm_pkg::MODE_CTRL_OFS);
	// other registers only in accessible stop
	assign wr_tick  = REG_WR & (mode == tcpm_pkg::TCPM_STOP_ACCESSIBLE) &
		(REG_ADDR == tcpm_pkg::TICK_PERIOD_OFS);

	function automatic logic [7:0] clamp_code(input logic [7:0] c);
		if (c > tcpm_pkg::TICK_CODE_MAX)
			return tcpm_pkg::TICK_CODE_MAX;
		return c;
	endfunction

	// a global reset is pulsed by writing bit four low; it reloads the mode
	// and tick period registers to their power-up values in the next cycle
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			mode_reg <= tcpm_pkg::MODE_RESET;
		end else if (!mode_reg[tcpm_pkg::GRST_POS]) begin
			mode_reg <= tcpm_pkg::MODE_RESET;
		end else begin
			if (wr_mode) begin
				mode_reg <= REG_WDATA & ~(8'h01 << tcpm_pkg::UNIMP_POS);
			end
			// the pin edge wins over a simultaneous write
			if (wake_fall) begin
				mode_reg[tcpm_pkg::DUTY_POS] <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			tick_period_reg <= tcpm_pkg::TICK_RESET;
		end else if (!mode_reg[tcpm_pkg::GRST_POS]) begin
			tick_period_reg <= tcpm_pkg::TICK_RESET;
		end else if (wr_tick) begin
			tick_period_reg <= clamp_code(REG_WDATA);
		end
	end

	// continuous run uses the programmed tick, every other mode the fixed one
	always_comb begin
		if (mode == tcpm_pkg::TCPM_RUN_CONTINUOUS)
			period_cyc = CNT_W'((32'(tick_period_reg) +
				tcpm_pkg::TICK_BASE_MS) * CYC_PER_MS);
		else
			period_cyc = CNT_W'(FIXED_TICK_CYC);
	end

	tcpm_tick #(.W(CNT_W)) u_tick (
		.clk        (CLK),
		.rst_b      (RST_B),
		.run        (scan_enable),
		.period_cyc (period_cyc),
		.tick       (TICK)
	);

	// interrupt spacing: after one leaves, wait factor+1 ticks
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			space_cnt_reg <= 4'h0;
			irq_pend_reg  <= 1'b0;
			IRQ_PULSE     <= 1'b0;
		end else if (!irq_output_enable) begin
			space_cnt_reg <= 4'h0;
			irq_pend_reg  <= 1'b0;
			IRQ_PULSE     <= 1'b0;
		end else begin
			IRQ_PULSE <= 1'b0;
			if (IRQ_REQ)
				irq_pend_reg <= 1'b1;
			if (space_cnt_reg != 4'h0 && TICK)
				space_cnt_reg <= space_cnt_reg - 4'h1;
			if ((irq_pend_reg || IRQ_REQ) && space_cnt_reg == 4'h0) begin
				IRQ_PULSE     <= 1'b1;
				irq_pend_reg  <= 1'b0;
				space_cnt_reg <= {1'b0, irq_spacing_factor} + 4'h1;
			end
		end
	end

	// reads answer in the next cycle, only while the bus is open
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			REG_RDATA <= 8'h00;
			REG_ACK   <= 1'b0;
		end else begin
			REG_ACK <= (REG_RD | REG_WR) & bus_open;
			if (REG_RD & bus_open) begin
				unique case (REG_ADDR)
					tcpm_pkg::TICK_PERIOD_OFS: REG_RDATA <= tick_period_reg;
					tcpm_pkg::MODE_CTRL_OFS:   REG_RDATA <= mode_reg;
					default:                   REG_RDATA <= 8'h00;
				endcase
			end
		end
	end

	// scanning in both run modes, low power when duty cycled or stopped off
	assign SCAN_ACTIVE  = scan_enable;
	assign LOW_POWER    = ~duty_cycle_off_n;
	assign BUS_AVAIL    = bus_open;
	assign GLOBAL_RST_N = mode_reg[tcpm_pkg::GRST_POS];
	assign MODE         = mode;
endmodule

// ===== tb/tcpm_host_model.sv
// host side model: drives the wake pin toward the controller
// assumes the pin idles high and the controller samples it
`timescale 1ns/100ps
module tcpm_host_model (
	output logic wake_pin
);
	initial wake_pin = 1'b1;
	// odd offset keeps the edge off the core clock grid
	task automatic pulse();
		#37;
		wake_pin = 1'b0;
		#125;
		wake_pin = 1'b1;
		#125;
	endtask
endmodule

// ===== tb/tcpm_top_props.sv
// assertions on the ports of the mode and power control top
// assumes wake pulses stay low for many core cycles
`timescale 1ns/100ps
module tcpm_props (
	input wire logic       CLK,
	input wire logic       RST_B,
	input wire logic       WAKE_PIN,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic       REG_ACK,
	input wire logic       IRQ_REQ,
	input wire logic       IRQ_PULSE,
	input wire logic       BUS_AVAIL,
	input wire logic       SCAN_ACTIVE,
	input wire logic       LOW_POWER,
	input wire logic       TICK,
	input wire logic       GLOBAL_RST_N,
	input wire logic [1:0] MODE
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_B);
	sequence s_mwr;
		REG_WR && BUS_AVAIL && REG_ADDR == tcpm_pkg::MODE_CTRL_OFS;
	endsequence
	sequence s_wfall;
		$fell(WAKE_PIN) ##1 !WAKE_PIN;
	endsequence
	property p_ack;
		(REG_WR || REG_RD) && BUS_AVAIL |=> REG_ACK;
	endproperty
	property p_refuse;
		(REG_WR || REG_RD) && !BUS_AVAIL |=> !REG_ACK;
	endproperty
	property p_bus;
		BUS_AVAIL == MODE[0] && LOW_POWER == !MODE[0];
	endproperty
	property p_scan;
		SCAN_ACTIVE == MODE[1];
	endproperty
	property p_notick;
		!SCAN_ACTIVE && !$past(SCAN_ACTIVE) |-> !TICK;
	endproperty
	property p_tgap;
		TICK |=> !TICK [*8];
	endproperty
	property p_wake;
		s_wfall |-> ##[0:4] MODE[0];
	endproperty
	property p_exit;
		$rose(BUS_AVAIL) |-> !$past(WAKE_PIN, 2) || !$past(GLOBAL_RST_N);
	endproperty
	property p_grst;
		s_mwr ##0 !REG_WDATA[4] |=> !GLOBAL_RST_N ##1 MODE == 2'h1;
	endproperty
	property p_mwr;
		logic [7:0] d;
		(s_mwr ##0 REG_WDATA[4], d = REG_WDATA) |=> MODE == {d[0], d[2]};
	endproperty
	property p_irq;
		IRQ_PULSE |=> !IRQ_PULSE until TICK;
	endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	a_refuse: assert property (p_refuse) else $error("ack on closed bus");
	a_bus: assert property (p_bus) else $error("bus state off");
	a_scan: assert property (p_scan) else $error("scan flag off");
	a_notick: assert property (p_notick) else $error("tick in stop");
	a_tgap: assert property (p_tgap) else $error("tick too close");
	a_wake: assert property (p_wake) else $error("wake ignored");
	a_exit: assert property (p_exit) else $error("exit without wake");
	a_grst: assert property (p_grst) else $error("global reset");
	a_mwr: assert property (p_mwr) else $error("mode write");
	a_irq: assert property (p_irq) else $error("irq spacing");
endmodule

bind tcpm_top tcpm_props u_tcpm_props (.*);

// ===== tb/tcpm_top_tb_top.sv
// self-checking bench for the mode and power control top
// assumes shortened tick counts: 10 cycles per ms, 80 cycle fixed tick
`timescale 1ns/100ps
module tcpm_top_tb_top;
	logic       clk, rst_b, reg_wr, reg_rd, irq_req, wake_pin, k;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
	logic [1:0] mode;
	logic       reg_ack, irq_pulse, bus_avail, scan, low_power, tick, grn;
	int         failures, samples_checked, n;

	tcpm_top #(.CYC_PER_MS(10), .FIXED_TICK_CYC(80)) u_tcpm_top (
		.CLK(clk), .RST_B(rst_b), .WAKE_PIN(wake_pin), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_RDATA(reg_rdata), .REG_ACK(reg_ack), .IRQ_REQ(irq_req),
		.IRQ_PULSE(irq_pulse), .BUS_AVAIL(bus_avail), .SCAN_ACTIVE(scan),
		.LOW_POWER(low_power), .TICK(tick), .GLOBAL_RST_N(grn), .MODE(mode));
	tcpm_host_model u_tcpm_host_model (.wake_pin(wake_pin));

	task automatic chk(input string nm, input logic [7:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, d, input logic ack);
		@(posedge clk);
		{reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
		@(posedge clk);
		{reg_wr, reg_rd} <= 2'h0;
		#1 chk("ack", {7'h00, reg_ack}, {7'h00, ack});
		q = reg_rdata;
	endtask
	task automatic rd(input logic [7:0] a, e, input logic ack);
		acc(1'b0, a, 8'h00, ack);
		if (ack) chk("rdata", q, e);
	endtask
	task automatic cm(input logic [1:0] e);
		chk("mode", {6'h00, mode}, {6'h00, e});
	endtask
	// cycles between two pulses of tick or irq, capped at 255
	task automatic per(input logic s, output int c);
		c = 0;
		while ((s ? irq_pulse : tick) !== 1'b1 && c < 255) begin
			@(negedge clk);
			c++;
		end
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while ((s ? irq_pulse : tick) !== 1'b1 && c < 255);
	endtask
	task automatic print_verdict();
		if (failures == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#80000;
		failures++;
		print_verdict();
	end
	initial begin
		{rst_b, reg_wr, reg_rd, irq_req, reg_addr, reg_wdata} = '0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		rd(8'h13, 8'h14, 1'b1);
		cm(2'h1);
		rd(8'h0e, 8'h05, 1'b1);
		rd(8'h22, 8'h00, 1'b1);
		acc(1'b1, 8'h0e, 8'h1b, 1'b1);
		rd(8'h0e, 8'h1a, 1'b1);
		acc(1'b1, 8'h0e, 8'hff, 1'b1);
		rd(8'h0e, 8'h1a, 1'b1);
		acc(1'b1, 8'h0e, 8'h00, 1'b1);
		acc(1'b1, 8'h13, 8'h3f, 1'b1);
		rd(8'h13, 8'h37, 1'b1);
		cm(2'h3);
		per(1'b0, n);
		chk("tick", 8'(n), 8'h32);
		acc(1'b1, 8'h0e, 8'h1a, 1'b1);
		rd(8'h0e, 8'h00, 1'b1);
		@(posedge clk) irq_req <= 1'b1;
		per(1'b1, n);
		per(1'b1, n);
		chk("irq gap", 8'(n), 8'h64);
		acc(1'b1, 8'h13, 8'h15, 1'b1);
		per(1'b1, n);
		chk("irq off", 8'(n), 8'hff);
		@(posedge clk) irq_req <= 1'b0;
		acc(1'b1, 8'h13, 8'h11, 1'b1);
		cm(2'h2);
		per(1'b0, n);
		chk("fixed tick", 8'(n), 8'h50);
		rd(8'h13, 8'h00, 1'b0);
		acc(1'b1, 8'h13, 8'h14, 1'b0);
		u_tcpm_host_model.pulse();
		cm(2'h3);
		rd(8'h13, 8'h15, 1'b1);
		acc(1'b1, 8'h13, 8'h10, 1'b1);
		cm(2'h0);
		rd(8'h13, 8'h00, 1'b0);
		u_tcpm_host_model.pulse();
		rd(8'h13, 8'h14, 1'b1);
		acc(1'b1, 8'h0e, 8'h03, 1'b1);
		acc(1'b1, 8'h13, 8'h04, 1'b1);
		chk("grst", {7'h00, grn}, 8'h00);
		rd(8'h13, 8'h14, 1'b1);
		rd(8'h0e, 8'h05, 1'b1);
		print_verdict();
	end
endmodule
